// ### ibr_pkg.sv
// Constants and types for the isolated-bus controller node
package ibr_pkg;

  // Core clock period in ns
  localparam int CLK_PERIOD_NS  = 10;
  // Nanoseconds in one bit period at one kbit/s
  localparam int NS_PER_KBIT    = 1_000_000;
  // Supported signalling rates in kbit/s
  localparam int RATE_KBPS_STD  = 100;
  localparam int RATE_KBPS_FAST = 400;
  localparam int RATE_KBPS_FMP  = 1000;
  // Quarter periods per bit
  localparam int QUARTERS       = 4;
  // Quarter-period timer width
  localparam int TIMER_W        = 16;

  // Quarter phases inside one bit or condition
  localparam logic [1:0] PH_SETUP  = 2'h0;
  localparam logic [1:0] PH_LOW    = 2'h1;
  localparam logic [1:0] PH_RISE   = 2'h2;
  localparam logic [1:0] PH_SAMPLE = 2'h3;

  // Bit index of the first bit and of the acknowledge slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] ACK_BIT   = 4'h8;

  // Direction bit values
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ  = 1'h1;

  // Byte counter values
  localparam logic [7:0] COUNT_NONE = 8'h00;
  localparam logic [7:0] COUNT_ONE  = 8'h01;

  // Controller sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_LOAD,
    ST_STOP
  } ibr_state_t;

  // One transfer request
  typedef struct packed {
    logic [6:0] addr;   // Target address
    logic       rw;     // Direction, 1 reads
    logic [7:0] count;  // Data bytes after the address
    logic       hold;   // End with bus kept for a repeated start
  } ibr_cmd_t;

  // End-of-transfer report
  typedef struct packed {
    logic done;   // Transfer finished
    logic nack;   // Target refused a byte
  } ibr_status_t;

endpackage : ibr_pkg

// ### ibr_controller.sv
// Controller node driving the isolated side of a two-wire bus repeater
//
// Function
// RQ1 - Repeater floats outputs while a supply is low
// RQ2 - Repeater forwards low, releases on high
// RQ3 - Every line needs a pull-up
// RQ4 - Repeater splits each line into two paths
// RQ5 - Standard, fast and fast-plus rates supported
// RQ6 - Repeater node-side low is weak, not echoed
// RQ7 - Bus-side low reaches node side after delay
// RQ8 - Bus-side release reaches node side after delay
// RQ9 - Node-side low reaches bus side after delay
// RQ10 - Weak low hidden under external strong low
// RQ11 - Node release frees bus side after delay
// RQ12 - Weak low removed one receive delay later
// RQ13 - Zero pulls line low, one releases it
// RQ14 - Data changes only while clock low
// RQ15 - START falls, STOP rises, clock high
// RQ16 - Address, direction bit, then released acknowledge
// RQ17 - Receiver holds data low through ninth pulse
// RQ18 - Address and data sent MSB first
// RQ19 - Reader acknowledges all bytes except last
// RQ20 - Transfer ends with STOP or repeated START
// RQ21 - One-way clock variant relays no stretching
// RQ22 - Repeater delays and variant are build options
// RQ23 - Bidirectional clock follows data sequencing
`timescale 1ns/10ps

module ibr_controller
  import ibr_pkg::*;
#(
  parameter int RATE_KBPS = RATE_KBPS_STD
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire ibr_cmd_t    cmd,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [7:0]  wr_data,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output ibr_status_t      status,
  input  wire logic        node_side_clock_i,
  output logic             node_side_clock_o,
  output logic             node_side_clock_oe,
  input  wire logic        node_side_data_i,
  output logic             node_side_data_o,
  output logic             node_side_data_oe
);

  // Quarter bit time, least time so rounded up
  localparam int QUARTER_NS     = NS_PER_KBIT / (QUARTERS * RATE_KBPS);
  localparam int QUARTER_RAW    = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUARTER_CYCLES = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;
  localparam logic [TIMER_W-1:0] RELOAD = TIMER_W'(QUARTER_CYCLES - 1);

  ibr_state_t         state;      // Sequencer state
  logic [1:0]         phase;      // Quarter within bit
  logic [TIMER_W-1:0] timer;      // Quarter countdown
  logic [3:0]         bitn;       // Bit in byte, 8 is acknowledge
  logic [7:0]         shift;      // Byte being sent or received
  logic [7:0]         remaining;  // Data bytes still to move
  logic               is_addr;    // Current byte is the address
  logic               rw;         // Latched direction
  logic               hold;       // Latched repeated-start request
  logic [1:0]         clk_sync;   // Clock line synchroniser
  logic [1:0]         dat_sync;   // Data line synchroniser

  // Synchronised line levels, second stage only
  wire clock_high = clk_sync[1];
  wire data_high  = dat_sync[1];

  // Quarter timing with stretch wait while clock held low
  wire tick  = (timer == '0);
  wire stall = (phase == PH_RISE) && !clock_high;
  wire step  = tick && !stall;
  wire timed = (state == ST_START) || (state == ST_BIT) || (state == ST_STOP);

  // Byte role and bit drive decisions
  wire tx_mode   = is_addr || (rw == RW_WRITE);
  wire ack_slot  = (bitn == ACK_BIT);
  wire last_rx   = (remaining == COUNT_ONE);
  wire ack_drive = !tx_mode && !last_rx;                   // see RQ19
  wire bit_drive = tx_mode && !shift[7];                   // see RQ13 see RQ18
  wire send_low  = ack_slot ? ack_drive : bit_drive;       // see RQ16 see RQ17

  // End-of-byte decisions
  wire        refused   = tx_mode && data_high;            // see RQ17
  wire [7:0]  left_next = is_addr ? remaining : remaining - COUNT_ONE;
  wire        byte_end  = (state == ST_BIT) && step && (phase == PH_SAMPLE) && ack_slot;
  wire        take_cmd  = (state == ST_IDLE) && cmd_valid && cmd_ready;
  wire        take_wr   = (state == ST_LOAD) && wr_valid && !wr_ready;

  // Pin inputs pass two flip-flops; released lines read high, see RQ3
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_sync <= 2'h3;
      dat_sync <= 2'h3;
    end else begin
      clk_sync <= {clk_sync[0], node_side_clock_i};
      dat_sync <= {dat_sync[0], node_side_data_i};
    end
  end

  // Quarter-period timer, reloaded on every phase step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer <= RELOAD;
    end else if (!timed || step) begin
      timer <= RELOAD;
    end else if (!tick) begin
      timer <= timer - 1'b1;
    end
  end

  // Phase counter walks four quarters per bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= PH_SETUP;
    end else if (!timed) begin
      phase <= PH_SETUP;
    end else if (step) begin
      phase <= phase + 1'b1;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      node_side_clock_o <= 1'h0;
      node_side_data_o  <= 1'h0;
    end else begin
      node_side_clock_o <= 1'h0;                           // see RQ13
      node_side_data_o  <= 1'h0;
    end
  end

  // Main sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state              <= ST_IDLE;
      bitn               <= BIT_FIRST;
      shift              <= 8'h00;
      remaining          <= COUNT_NONE;
      is_addr            <= 1'h0;
      rw                 <= RW_WRITE;
      hold               <= 1'h0;
      cmd_ready          <= 1'h1;
      wr_ready           <= 1'h0;
      rd_valid           <= 1'h0;
      rd_data            <= 8'h00;
      status             <= '0;
      node_side_clock_oe <= 1'h0;
      node_side_data_oe  <= 1'h0;
    end else begin
      // Pulses last one cycle
      wr_ready <= 1'h0;
      rd_valid <= 1'h0;
      status   <= '0;
      unique case (state)
        // Wait for a request; clock stays low if bus is held
        ST_IDLE: begin
          if (take_cmd) begin
            cmd_ready         <= 1'h0;
            rw                <= cmd.rw;
            hold              <= cmd.hold;
            remaining         <= cmd.count;
            shift             <= {cmd.addr, cmd.rw};       // see RQ16
            node_side_data_oe <= 1'h0;
            state             <= ST_START;
          end
        end
        // Start or repeated start: data falls with clock high
        ST_START: begin
          if (step) begin
            unique case (phase)
              PH_SETUP:  ;
              PH_LOW:    node_side_clock_oe <= 1'h0;
              PH_RISE:   node_side_data_oe  <= 1'h1;       // see RQ15
              PH_SAMPLE: begin
                node_side_clock_oe <= 1'h1;
                is_addr            <= 1'h1;
                bitn               <= BIT_FIRST;
                state              <= ST_BIT;
              end
            endcase
          end
        end
        // One bit: set data drive, raise clock, sample high, drop clock
        ST_BIT: begin
          if (step) begin
            unique case (phase)
              PH_SETUP:  node_side_data_oe  <= send_low;   // see RQ14
              PH_LOW:    node_side_clock_oe <= 1'h0;
              PH_RISE:   ;
              PH_SAMPLE: begin
                node_side_clock_oe <= 1'h1;
                if (!ack_slot) begin
                  shift <= {shift[6:0], data_high};        // see RQ18
                  bitn  <= bitn + 1'b1;
                end
              end
            endcase
          end
          // Acknowledge slot closes the byte
          if (byte_end) begin
            remaining <= left_next;
            is_addr   <= 1'h0;
            bitn      <= BIT_FIRST;
            if (!tx_mode) begin
              rd_valid <= 1'h1;
              rd_data  <= shift;
            end
            if (refused) begin
              status.nack <= 1'h1;
              state       <= ST_STOP;
            end else if (left_next == COUNT_NONE) begin
              if (hold) begin                              // see RQ20
                status.done <= 1'h1;
                cmd_ready   <= 1'h1;
                state       <= ST_IDLE;
              end else begin
                state <= ST_STOP;
              end
            end else if (rw == RW_READ) begin
              state <= ST_BIT;
            end else begin
              state <= ST_LOAD;
            end
          end
        end
        // Clock held low until the next write byte arrives
        ST_LOAD: begin
          if (take_wr) begin
            wr_ready <= 1'h1;
            shift    <= wr_data;
            state    <= ST_BIT;
          end
        end
        // Stop: data rises with clock high
        ST_STOP: begin
          if (step) begin
            unique case (phase)
              PH_SETUP:  node_side_data_oe  <= 1'h1;
              PH_LOW:    node_side_clock_oe <= 1'h0;
              PH_RISE:   node_side_data_oe  <= 1'h0;       // see RQ15 see RQ20
              PH_SAMPLE: begin
                status.done <= 1'h1;
                cmd_ready   <= 1'h1;
                state       <= ST_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule : ibr_controller

// ### ibr_controller_checker.sv
// Port assertions for the isolated-bus controller node
`timescale 1ns/10ps
module ibr_controller_checker
  import ibr_pkg::*;
#(
  parameter int RATE_KBPS = RATE_KBPS_STD
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        wr_ready,
  input wire logic        rd_valid,
  input wire ibr_status_t status,
  input wire logic        node_side_clock_o,
  input wire logic        node_side_clock_oe,
  input wire logic        node_side_data_o,
  input wire logic        node_side_data_oe
);
  // Quarter length in cycles and the bounds built on it
  localparam int QC = (NS_PER_KBIT / (QUARTERS * RATE_KBPS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_MAX = QC + 15;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_pull_only: assert property (!node_side_data_o && !node_side_clock_o)
    else $error("pin output level not low");
  chk_start_form: assert property ($rose(node_side_data_oe) && !node_side_clock_oe
    |-> ##[1:START_MAX] node_side_clock_oe) else $error("start not followed by clock low");
  chk_stop_done: assert property ($fell(node_side_data_oe) && !node_side_clock_oe
    |-> ##[1:START_MAX] status.done) else $error("stop not followed by done");
  chk_nack_stop: assert property (status.nack |-> ##[1:START_MAX] node_side_data_oe)
    else $error("refusal not ended by stop");
  chk_low_min: assert property ($rose(node_side_clock_oe) |-> node_side_clock_oe[*8])
    else $error("clock low phase too short");
  chk_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stays high after take");
  chk_ready_done: assert property ($rose(cmd_ready) |-> status.done)
    else $error("ready returns without done");
  chk_wr_pulse: assert property (wr_ready |=> !wr_ready)
    else $error("write ready longer than one cycle");
  chk_rd_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
endmodule : ibr_controller_checker

bind ibr_controller ibr_controller_checker #(.RATE_KBPS(RATE_KBPS)) u_chk (
  .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .wr_ready(wr_ready), .rd_valid(rd_valid), .status(status),
  .node_side_clock_o(node_side_clock_o), .node_side_clock_oe(node_side_clock_oe),
  .node_side_data_o(node_side_data_o), .node_side_data_oe(node_side_data_oe));

// ### ibr_repeater_model.sv
// Repeater model with pulled-up lines and one target on the bus side
`timescale 1ns/10ps
module ibr_repeater_model #(
  parameter int         TX_NS     = 70,     // Node to bus delay
  parameter int         RX_NS     = 50,     // Bus to node delay
  parameter bit         BIDIR_CLK = 1'b1,   // Clock return path present
  parameter logic [6:0] TGT_ADDR  = 7'h2C,
  parameter logic [7:0] TGT_DATA  = 8'h5A
) (
  input  wire logic       supply_ok,
  input  wire logic       node_clock_drive,
  input  wire logic       node_data_drive,
  output wire logic       node_side_clock,
  output wire logic       node_side_data,
  output logic [7:0]      last_byte
);
  logic tx_clk, tx_dat, rx_clk, rx_dat, tgt_oe, addr_ph, sel, rd;
  logic [7:0] sh, rdb;
  int bitn;
  wire logic bus_side_clock, bus_side_data;
  // Only a strong node low crosses; outputs float without supply
  assign #(TX_NS) tx_dat = supply_ok && node_data_drive;
  assign #(TX_NS) tx_clk = supply_ok && node_clock_drive;
  // Bus lows return as a weak low
  assign #(RX_NS) rx_dat = supply_ok && !bus_side_data;
  assign #(RX_NS) rx_clk = supply_ok && BIDIR_CLK && !bus_side_clock;
  // Open-drain lines with pull-ups
  assign bus_side_data   = !(tx_dat || tgt_oe);
  assign bus_side_clock  = !tx_clk;
  assign node_side_data  = !(node_data_drive || rx_dat);
  assign node_side_clock = !(node_clock_drive || rx_clk);
  initial begin
    {bitn, sh, sel, rd, tgt_oe, last_byte} = '0;
    addr_ph = 1'b1;
    rdb = TGT_DATA;
  end
  // Start restarts the target
  always @(negedge bus_side_data) if (bus_side_clock) begin
    {bitn, sel, rd, tgt_oe} = '0;
    addr_ph = 1'b1;
  end
  // Bits shift in MSB first
  always @(posedge bus_side_clock) begin
    sh = {sh[6:0], bus_side_data};
    bitn++;
  end
  // Target changes its drive on a clock fall, or clears it on a start, and holds it through the high phase
  always @(negedge bus_side_clock) begin
    if (bitn == 8) begin
      if (addr_ph) begin
        sel = (sh[7:1] == TGT_ADDR);
        rd = sel && sh[0];
      end else if (sel && !rd) last_byte = sh;
      tgt_oe = sel && (addr_ph || !rd);
    end else begin
      if (bitn == 9) begin
        bitn = 0;
        if (rd && !addr_ph) begin
          rdb++;
          rd = !sh[0];
        end
        addr_ph = 1'b0;
      end
      tgt_oe = rd && !rdb[7 - bitn];
    end
  end
endmodule : ibr_repeater_model

// ### ibr_controller_tb.sv
// Self-checking bench: controller through the repeater to one target
`timescale 1ns/10ps
module ibr_controller_tb;
  import ibr_pkg::*;
  localparam logic [6:0] TGT = 7'h2C;
  localparam logic [7:0] RD0 = 8'h5A;
  logic        clk, reset, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, nack_seen;
  logic        sc_o, sc_oe, sd_o, sd_oe;
  logic [7:0]  wr_data, rd_data, last_byte, nxt, b;
  ibr_cmd_t    cmd;
  ibr_status_t status;
  wire logic   sc_i, sd_i;
  int          miscompares, check_count, seed;
  logic [7:0]  exp_q[$];  // Expected read bytes
  logic        exp_n[$];  // Expected refusal per transfer
  ibr_controller #(.RATE_KBPS(RATE_KBPS_FMP)) dut (.clk(clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .status(status), .node_side_clock_i(sc_i), .node_side_clock_o(sc_o),
    .node_side_clock_oe(sc_oe), .node_side_data_i(sd_i), .node_side_data_o(sd_o),
    .node_side_data_oe(sd_oe));
  ibr_repeater_model #(.TGT_ADDR(TGT), .TGT_DATA(RD0)) u_rep (.supply_ok(1'b1),
    .node_clock_drive(sc_oe), .node_data_drive(sd_oe), .node_side_clock(sc_i),
    .node_side_data(sd_i), .last_byte(last_byte));
  // Core clock
  always #5 clk = ~clk;
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // One whole transfer; notes go to the queues first
  task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] n,
                      input logic hold, input logic [7:0] d);
    int t;
    exp_n.push_back(a != TGT);
    if (rw && a == TGT) for (t = 0; t < n; t++) exp_q.push_back(nxt++);
    @(negedge clk);
    cmd = '{addr: a, rw: rw, count: n, hold: hold};
    cmd_valid = 1'b1;
    wr_data = d;
    wr_valid = !rw;
    @(negedge clk);
    cmd_valid = 1'b0;
    check("cmd_ready", {7'h0, cmd_ready}, 8'h00);
    for (t = 0; t < 9000 && status.done !== 1'b1; t++) begin
      @(negedge clk);
      if (wr_ready === 1'b1) wr_valid = 1'b0;
    end
    // A transfer that never finishes counts as a mismatch
    if (status.done !== 1'b1) miscompares++;
    wr_valid = 1'b0;
  endtask : xfer
  // Scoreboard: oldest note against each result
  always @(negedge clk) begin
    if (status.nack === 1'b1) nack_seen = 1'b1;
    if (rd_valid === 1'b1) check("rd_data", rd_data, exp_q.pop_front());
    if (status.done === 1'b1) begin
      check("nack", {7'h0, nack_seen}, {7'h0, exp_n.pop_front()});
      nack_seen = 1'b0;
    end
  end
  // Watchdog against a hang
  initial begin
    #500_000;
    miscompares++;
    results();
  end
  initial begin
    {clk, cmd_valid, wr_valid, nack_seen, miscompares, check_count} = '0;
    {cmd, wr_data} = '0;
    reset = 1'b1;
    seed = 32'h3366;
    nxt = RD0;
    repeat (12) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    check("lines", {6'h0, sc_oe, sd_oe}, 8'h00);
    xfer(TGT, RW_READ, 8'h02, 1'b1, 8'h00);
    b = 8'($random(seed));
    xfer(TGT, RW_WRITE, 8'h01, 1'b0, b);
    check("last_byte", last_byte, b);
    xfer(TGT ^ 7'h01, RW_WRITE, 8'h01, 1'b0, ~b);
    xfer(TGT, RW_READ, 8'h01, 1'b0, 8'h00);
    check("left", 8'(exp_q.size()), 8'h00);
    results();
  end
endmodule : ibr_controller_tb
